// ### hdl/ubrg_pkg.sv
// package: register map, field positions, reset values and timing constants
package ubrg_pkg;

    // register word offsets (byte addresses)
    localparam logic [7:0] ADDR_TX_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL   = 8'h04;
    localparam logic [7:0] ADDR_BAUD_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH  = 8'h0C;
    localparam logic [7:0] ADDR_DIV_LOW   = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;

    // serial_transmit_control fields
    localparam int BIT_MASTER_CLOCK = 7;
    localparam int BIT_SYNC_MODE    = 4;
    localparam int BIT_HIGH_SPEED   = 2;
    // serial_receive_control fields
    localparam int BIT_PORT_ENABLE  = 7;
    // baud_control fields
    localparam int BIT_WIDE_DIVISOR = 3;
    localparam logic [7:0] TX_CTRL_WMASK   = 8'hFD;
    localparam logic [7:0] TX_CTRL_SHIFT_EMPTY = 8'h02;
    localparam logic [7:0] RX_CTRL_WMASK   = 8'hF8;
    localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
    localparam logic [7:0] BAUD_CTRL_IDLE  = 8'h40;

    // reset values
    localparam logic [7:0] RST_TX_CTRL   = 8'h00;
    localparam logic [7:0] RST_RX_CTRL   = 8'h00;
    localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
    localparam logic [7:0] RST_DIV       = 8'h00;

    // prescale factors of the rate formulas
    localparam logic [5:0] PRE_64 = 6'h3F;
    localparam logic [5:0] PRE_16 = 6'h0F;
    localparam logic [5:0] PRE_4  = 6'h03;

    // majority sampling: number of samples
    localparam int RX_SAMPLES = 3;

    typedef struct packed {
        logic       port_enable;
        logic       sync_mode;
        logic       master_clock;
        logic       high_speed;
        logic       wide_divisor;
        logic [15:0] divisor;
    } ubrg_cfg_s;

endpackage : ubrg_pkg

// ### hdl/ubrg_prescale.sv
// prescaler that turns every limit + 1 divisor overflows into one baud tick
`timescale 1ns/1ps
module ubrg_prescale (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       step,
    input  wire logic [5:0] limit,
    output logic            tick
);
    logic [5:0] count;
    wire        at_limit = (count >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 6'h00;
            tick  <= 1'b0;
        end else if (clear) begin
            count <= 6'h00;
            tick  <= 1'b0;
        end else begin
            tick <= step && at_limit;
            if (step) begin
                count <= at_limit ? 6'h00 : count + 6'h01;
            end
        end
    end
endmodule : ubrg_prescale

// ### hdl/ubrg_majority.sv
// three-sample majority vote on the receive pin
`timescale 1ns/1ps
module ubrg_majority (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sample_en,
    input  wire logic receive_pin,
    output logic      level
);
    logic [ubrg_pkg::RX_SAMPLES-1:0] hist;
    wire vote = (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist  <= 3'b111;
            level <= 1'b1;
        end else begin
            if (sample_en) begin
                hist <= {hist[1:0], receive_pin};
            end
            level <= vote;
        end
    end
endmodule : ubrg_majority

// ### hdl/ubrg_top.sv
// baud rate generator with apb registers and receive majority detector
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ubrg_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        receive_pin,
    input  wire logic        ext_shift_clock,
    output logic             baud_tick,
    output logic             shift_clock_tick,
    output logic             receive_level
);
    logic [7:0]          serial_transmit_control;
    logic [7:0]          serial_receive_control;
    logic [7:0]          baud_control;
    logic [7:0]          divisor_high_byte;
    logic [7:0]          divisor_low_byte;
    logic [15:0]         timer;
    logic                ext_clk_d;
    logic                tick_raw;
    logic                rx_level;
    ubrg_pkg::ubrg_cfg_s cfg;

    // apb: one wait state, unmapped addresses answer with pslverr
    wire access   = psel && penable;
    // write lands only at the edge that completes the transfer
    wire wr       = access && pwrite && pready;
    wire hit_tx   = (paddr == ubrg_pkg::ADDR_TX_CTRL);
    wire hit_rx   = (paddr == ubrg_pkg::ADDR_RX_CTRL);
    wire hit_baud = (paddr == ubrg_pkg::ADDR_BAUD_CTRL);
    wire hit_divh = (paddr == ubrg_pkg::ADDR_DIV_HIGH);
    wire hit_divl = (paddr == ubrg_pkg::ADDR_DIV_LOW);
    wire hit_stat = (paddr == ubrg_pkg::ADDR_STATUS);
    wire mapped   = hit_tx | hit_rx | hit_baud | hit_divh | hit_divl | hit_stat;

    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction : merge

    // configuration view
    always_comb begin
        cfg.port_enable  = serial_receive_control[ubrg_pkg::BIT_PORT_ENABLE];
        cfg.sync_mode    = serial_transmit_control[ubrg_pkg::BIT_SYNC_MODE];
        cfg.master_clock = serial_transmit_control[ubrg_pkg::BIT_MASTER_CLOCK];
        cfg.high_speed   = serial_transmit_control[ubrg_pkg::BIT_HIGH_SPEED];
        cfg.wide_divisor = baud_control[ubrg_pkg::BIT_WIDE_DIVISOR];
        // high byte ignored in narrow width
        cfg.divisor      = cfg.wide_divisor ? {divisor_high_byte, divisor_low_byte}
                                            : {8'h00, divisor_low_byte};
    end

    // prescale selection after each timer overflow
    wire [5:0] prescale_limit =
        cfg.sync_mode ? ubrg_pkg::PRE_4 :
        (cfg.wide_divisor ? (cfg.high_speed ? ubrg_pkg::PRE_4 : ubrg_pkg::PRE_16)
                          : (cfg.high_speed ? ubrg_pkg::PRE_16 : ubrg_pkg::PRE_64));

    wire div_write = wr && (hit_divh || hit_divl);
    wire gen_clear = div_write || !cfg.port_enable || (wr && (hit_tx || hit_baud));
    // divisor 0 reloads every cycle, so async rates stay exact down to n = 0
    wire overflow  = (timer >= cfg.divisor);

    // free-running timer on the system clock, no second clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= 16'h0000;
        end else if (gen_clear) begin
            timer <= 16'h0000;
        end else begin
            timer <= overflow ? 16'h0000 : timer + 16'h0001;
        end
    end

    ubrg_prescale u_prescale (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (gen_clear),
        .step    (overflow),
        .limit   (prescale_limit),
        .tick    (tick_raw)
    );

    // majority of the last three samples, one taken on every overflow while port_enable is set
    ubrg_majority u_majority (
        .pclk        (pclk),
        .presetn     (presetn),
        .sample_en   (overflow && cfg.port_enable),
        .receive_pin (receive_pin),
        .level       (rx_level)
    );

    wire ext_rise  = ext_shift_clock && !ext_clk_d;
    wire is_slave  = cfg.sync_mode && !cfg.master_clock;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_clk_d        <= 1'b0;
            baud_tick        <= 1'b0;
            shift_clock_tick <= 1'b0;
            receive_level    <= 1'b1;
        end else begin
            ext_clk_d        <= ext_shift_clock;
            baud_tick        <= tick_raw && cfg.port_enable;
            // slave follows the external clock, master the generator
            shift_clock_tick <= cfg.port_enable && cfg.sync_mode &&
                                (is_slave ? ext_rise : tick_raw);
            receive_level    <= rx_level;
        end
    end

    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_transmit_control <= ubrg_pkg::RST_TX_CTRL;
            serial_receive_control  <= ubrg_pkg::RST_RX_CTRL;
            baud_control            <= ubrg_pkg::RST_BAUD_CTRL;
            divisor_high_byte       <= ubrg_pkg::RST_DIV;
            divisor_low_byte        <= ubrg_pkg::RST_DIV;
        end else if (wr) begin
            if (hit_tx) begin
                serial_transmit_control <= merge(serial_transmit_control, pwdata[7:0],
                                                 ubrg_pkg::TX_CTRL_WMASK);
            end
            if (hit_rx) begin
                serial_receive_control <= merge(serial_receive_control, pwdata[7:0],
                                                ubrg_pkg::RX_CTRL_WMASK);
            end
            if (hit_baud) begin
                baud_control <= merge(baud_control, pwdata[7:0], ubrg_pkg::BAUD_CTRL_WMASK);
            end
            if (hit_divh) begin
                divisor_high_byte <= pwdata[7:0];
            end
            if (hit_divl) begin
                divisor_low_byte <= pwdata[7:0];
            end
        end
    end

    // read mux; transmitter and receiver are elsewhere, so they read idle
    wire [7:0] rd_byte =
        hit_tx   ? (serial_transmit_control | ubrg_pkg::TX_CTRL_SHIFT_EMPTY) :
        hit_rx   ? serial_receive_control :
        hit_baud ? (baud_control | ubrg_pkg::BAUD_CTRL_IDLE) :
        hit_divh ? divisor_high_byte :
        hit_divl ? divisor_low_byte :
        hit_stat ? {7'h00, rx_level} : 8'h00;
    wire [31:0] rd_word = hit_stat ? {timer, 15'h0000, rx_level} : {24'h000000, rd_byte};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // answer one cycle into the access phase
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= (psel && !pwrite) ? rd_word : 32'h00000000;
        end
    end
endmodule : ubrg_top

// ### verification/ubrg_properties.sv
// checker for bus handshake, responses and tick spacing
`timescale 1ns/1ps
module ubrg_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        receive_pin,
    input wire logic        ext_shift_clock,
    input wire logic        baud_tick,
    input wire logic        shift_clock_tick,
    input wire logic        receive_level
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_reply;
        pready ##1 !pready;
    endsequence
    a_one_wait: assert property (s_access |=> s_reply)
        else $error("ready not one cycle after access");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access");
    a_unmapped_error: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_okay: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("error outside reply");
    a_upper_zero: assert property (pready && !pwrite && paddr != 8'h14 |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    // shortest period is 4 x (0 + 1) cycles
    a_tick_gap: assert property (baud_tick |=> !baud_tick [*3])
        else $error("baud ticks too close");
    a_level_reset_high: assert property ($rose(presetn) |-> receive_level)
        else $error("receive level not high after reset");
    // a tick already launched may still show one cycle after the write
    a_clear_quiet: assert property (pready && pwrite && !pslverr &&
        (paddr == ubrg_pkg::ADDR_DIV_HIGH || paddr == ubrg_pkg::ADDR_DIV_LOW)
        |=> ##1 !baud_tick [*3])
        else $error("baud tick too soon after divisor write");
endmodule : ubrg_properties

bind ubrg_top ubrg_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_pin(receive_pin),
    .ext_shift_clock(ext_shift_clock), .baud_tick(baud_tick),
    .shift_clock_tick(shift_clock_tick), .receive_level(receive_level));

// ### verification/ubrg_bench.sv
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module ubrg_bench;
    logic        pclk, presetn, psel, penable, pwrite, receive_pin, ext_shift_clock;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, baud_tick, shift_clock_tick, receive_level, er;
    int          fails, samples_checked, c, k;
    ubrg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .receive_pin(receive_pin), .ext_shift_clock(ext_shift_clock),
        .baud_tick(baud_tick), .shift_clock_tick(shift_clock_tick),
        .receive_level(receive_level));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic end_sim;
        if (fails == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // a hung wait ends the run at once
    task automatic guard(input logic ok);
        if (!ok) begin
            fails++;
            end_sim();
        end
    endtask : guard
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        guard(n < 20);
        @(posedge pclk);
    endtask : bus
    task automatic wait_tick(input int lim);
        c = 0;
        while (baud_tick !== 1'b1 && c < lim) begin @(posedge pclk); c++; end
        guard(c < lim);
    endtask : wait_tick
    // measure between two later ticks: the first after setup may be partial
    task automatic rate(input logic [7:0] tx, bc, hi, lo, input logic [31:0] exp);
        // leave sync mode while the divisor passes through 0 or 1
        bus(1'b1, ubrg_pkg::ADDR_TX_CTRL, tx & 8'hEF);
        bus(1'b1, ubrg_pkg::ADDR_BAUD_CTRL, bc);
        bus(1'b1, ubrg_pkg::ADDR_DIV_HIGH, hi);
        bus(1'b1, ubrg_pkg::ADDR_DIV_LOW, lo);
        bus(1'b1, ubrg_pkg::ADDR_TX_CTRL, tx);
        wait_tick(9000);
        @(posedge pclk);
        wait_tick(9000);
        chk(c + 1, exp);
    endtask : rate
    task automatic regs;
        bus(1'b0, ubrg_pkg::ADDR_TX_CTRL, 8'h00);
        chk(rd, 32'h02);
        bus(1'b0, ubrg_pkg::ADDR_BAUD_CTRL, 8'h00);
        chk(rd, 32'h40);
        bus(1'b0, ubrg_pkg::ADDR_DIV_LOW, 8'h00);
        chk(rd, 32'h00);
        bus(1'b1, ubrg_pkg::ADDR_BAUD_CTRL, 8'hFF);
        bus(1'b0, ubrg_pkg::ADDR_BAUD_CTRL, 8'h00);
        chk(rd, 32'h7B);
        bus(1'b0, 8'h20, 8'h00);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
    endtask : regs
    task automatic rates;
        bus(1'b1, ubrg_pkg::ADDR_RX_CTRL, 8'h80);
        rate(8'h00, 8'h00, 8'h05, 8'h02, 32'd192);
        rate(8'h00, 8'h08, 8'h01, 8'h00, 32'd4112);
        rate(8'h04, 8'h00, 8'h00, 8'h00, 32'd16);
        rate(8'h04, 8'h08, 8'h00, 8'h01, 32'd8);
        rate(8'h94, 8'h00, 8'h00, 8'h05, 32'd24);
    endtask : rates
    task automatic restart;
        rate(8'h04, 8'h08, 8'h01, 8'h00, 32'd1028);
        repeat (100) @(posedge pclk);
        // same value again: only the restart can push the next tick out
        bus(1'b1, ubrg_pkg::ADDR_DIV_LOW, 8'h00);
        wait_tick(2000);
        chk(c >= 1000, 32'h1);
        repeat (100) @(posedge pclk);
        bus(1'b1, ubrg_pkg::ADDR_DIV_HIGH, 8'h00);
        bus(1'b1, ubrg_pkg::ADDR_DIV_LOW, 8'h01);
        wait_tick(2000);
        chk(c <= 12, 32'h1);
    endtask : restart
    task automatic slave;
        bus(1'b1, ubrg_pkg::ADDR_DIV_LOW, 8'h05);
        bus(1'b1, ubrg_pkg::ADDR_TX_CTRL, 8'h10);
        k = 0;
        for (int i = 0; i < 30; i++) begin
            ext_shift_clock <= (i % 6) >= 3 && i < 24;
            @(posedge pclk);
            if (shift_clock_tick === 1'b1) k++;
        end
        chk(k, 32'd4);
    endtask : slave
    task automatic majority;
        bus(1'b1, ubrg_pkg::ADDR_TX_CTRL, 8'h00);
        bus(1'b1, ubrg_pkg::ADDR_DIV_LOW, 8'h00);
        receive_pin <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({31'h0, receive_level}, 32'h0);
        receive_pin <= 1'b1;
        @(posedge pclk);
        receive_pin <= 1'b0;
        k = 0;
        repeat (8) begin @(posedge pclk); if (receive_level !== 1'b0) k++; end
        chk(k, 32'd0);
        bus(1'b0, ubrg_pkg::ADDR_STATUS, 8'h00);
        chk({31'h0, rd[0]}, 32'h0);
    endtask : majority
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ext_shift_clock} = '0;
        receive_pin = 1'b1;
        fails = 0;
        samples_checked = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regs();
        rates();
        restart();
        slave();
        majority();
        end_sim();
    end
endmodule : ubrg_bench
